//--- logic/smc_divider.sv
// Clock-enable divider: one pulse every div_i cycles while run_i is high.
// Assumes div_i is at least 1; it restarts from zero whenever run_i drops.
`timescale 1ns/1ps
module smc_divider
    import smc_pkg::*;
#(
    parameter int DIV_W = SMC_DIV_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    // Enable pulse
    output logic tick_o
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;

    // Refuse counter widths too narrow for a useful divide
    if (DIV_W < 2) begin : g_bad_w
        $error("smc_divider: DIV_W below 2");
    end

    // Next count
    always_comb begin
        cnt_d = '0;
        if (run_i && (cnt_q + DIV_W'(1) < div_i)) begin
            cnt_d = cnt_q + DIV_W'(1);
        end
    end

    // Count register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick_o = run_i && (cnt_q + DIV_W'(1) >= div_i);
endmodule

//--- logic/smc_master.sv
// Two independent serial master channels with word exchange and bulk transfers.
// Assumes the host drives chip select elsewhere and holds start data stable.
`timescale 1ns/1ps
module smc_master
    import smc_pkg::*;
#(
    parameter int NCH = 2,
    parameter int CLK_HZ = SMC_CLK_HZ
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Channel configuration, one entry per channel
    input wire logic [NCH-1:0] open_i,
    input wire logic [NCH*32-1:0] rate_hz_i,
    input wire logic [NCH*2-1:0] mode_i,
    input wire logic [NCH*5-1:0] bits_i,
    // Transfer requests
    input wire logic [NCH-1:0] start_i,
    input wire logic [NCH*2-1:0] op_i,
    input wire logic [NCH*SMC_CNT_W-1:0] count_i,
    input wire logic [NCH*16-1:0] wdata_i,
    output logic [NCH-1:0] wdata_req_o,
    // Results
    output logic [NCH*16-1:0] rdata_o,
    output logic [NCH-1:0] rvalid_o,
    output logic [NCH-1:0] done_o,
    output logic [NCH-1:0] busy_o,
    output logic [NCH-1:0] opened_o,
    // Serial pins
    output logic [NCH-1:0] sclk_o,
    output logic [NCH-1:0] mosi_o,
    output logic [NCH-1:0] pin_oe_o,
    input wire logic [NCH-1:0] miso_i
);
    // Refuse channel counts and clock rates the logic cannot serve
    if (NCH < 1 || CLK_HZ < 2) begin : g_bad_cfg
        $error("smc_master: bad NCH or CLK_HZ");
    end

    ////////////////////////////////////////////////////////////////////////////
    // One channel per generate entry
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic open_q, open_d;
            logic [1:0] mode_q, mode_d;
            logic [4:0] bits_q, bits_d;
            logic [SMC_DIV_W-1:0] div_q, div_d;
            smc_state_t st_q, st_d;
            smc_op_t op_q, op_d;
            logic [15:0] tx_q, tx_d, rx_q, rx_d, rd_q, rd_d;
            logic [4:0] bit_q, bit_d;
            logic [SMC_CNT_W-1:0] left_q, left_d;
            logic sclk_q, sclk_d, mosi_q, mosi_d;
            logic rv_q, rv_d, dn_q, dn_d, wr_q, wr_d;
            logic miso_m_q, miso_s_q;
            logic tick;
            logic [31:0] rate;
            logic [31:0] half;
            logic cpol, cpha;
            logic [15:0] nxt_word;

            assign rate = rate_hz_i[g*32 +: 32];
            assign cpol = mode_q[1];
            assign cpha = mode_q[0];

            // Half period in system cycles from the rate in hertz
            always_comb begin
                half = (rate == 32'h0) ? 32'hffff : 32'(CLK_HZ) / (rate << 1);
                if (half == 32'h0) begin
                    half = 32'h1;
                end else if (half > 32'hffff) begin
                    half = 32'hffff;
                end
            end

            smc_divider #(.DIV_W(SMC_DIV_W)) u_div (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .run_i(st_q != SMC_IDLE),
                .div_i(div_q),
                .tick_o(tick)
            );

            // Word to load: zeros for bulk read, else host data
            assign nxt_word = (smc_op_t'(op_i[g*2 +: 2]) == SMC_OP_BRD) ?
                              16'h0 : wdata_i[g*16 +: 16];

            // Next channel state
            always_comb begin
                open_d = open_q;
                mode_d = mode_q;
                bits_d = bits_q;
                div_d = div_q;
                st_d = st_q;
                op_d = op_q;
                tx_d = tx_q;
                rx_d = rx_q;
                rd_d = rd_q;
                bit_d = bit_q;
                left_d = left_q;
                sclk_d = sclk_q;
                mosi_d = mosi_q;
                rv_d = 1'b0;
                dn_d = 1'b0;
                wr_d = 1'b0;
                unique case (st_q)
                    SMC_IDLE: begin
                        open_d = open_i[g];
                        if (open_i[g] && !open_q) begin
                            mode_d = mode_i[g*2 +: 2];
                            bits_d = (bits_i[g*5 +: 5] < 5'(SMC_MIN_BITS)) ?
                                     5'(SMC_MIN_BITS) :
                                     (bits_i[g*5 +: 5] > 5'(SMC_MAX_BITS)) ?
                                     5'(SMC_MAX_BITS) : bits_i[g*5 +: 5];
                            div_d = half[SMC_DIV_W-1:0];
                        end
                        sclk_d = open_i[g] ? (open_q ? cpol : mode_i[g*2+1]) : 1'b0;
                        mosi_d = 1'b0;
                        if (open_q && open_i[g] && start_i[g]) begin
                            op_d = smc_op_t'(op_i[g*2 +: 2]);
                            left_d = (smc_op_t'(op_i[g*2 +: 2]) == SMC_OP_XCHG) ?
                                     SMC_CNT_W'(1) : count_i[g*SMC_CNT_W +: SMC_CNT_W];
                            // Left-justify so bit 15 is always the next to send
                            tx_d = nxt_word << (5'd16 - bits_q);
                            bit_d = bits_q;
                            if (count_i[g*SMC_CNT_W +: SMC_CNT_W] != '0 ||
                                smc_op_t'(op_i[g*2 +: 2]) == SMC_OP_XCHG) begin
                                st_d = SMC_LEAD;
                                // Ask for a word only when one really goes out
                                wr_d = (smc_op_t'(op_i[g*2 +: 2]) != SMC_OP_BRD);
                                mosi_d = cpha ? 1'b0 : tx_d[15];
                            end else begin
                                dn_d = 1'b1;
                            end
                        end
                    end
                    SMC_LEAD: if (tick) begin
                        // First edge: sample when phase 0, shift out when phase 1
                        sclk_d = ~cpol;
                        if (cpha) begin
                            mosi_d = tx_q[15];
                            tx_d = {tx_q[14:0], 1'b0};
                        end else begin
                            rx_d = {rx_q[14:0], miso_s_q};
                        end
                        st_d = SMC_TRAIL;
                    end
                    SMC_TRAIL: if (tick) begin
                        // Second edge: the opposite action
                        sclk_d = cpol;
                        bit_d = bit_q - 5'd1;
                        if (cpha) begin
                            rx_d = {rx_q[14:0], miso_s_q};
                        end else begin
                            tx_d = {tx_q[14:0], 1'b0};
                        end
                        st_d = (bit_q == 5'd1) ? SMC_NEXT : SMC_LEAD;
                        if (!cpha && bit_q != 5'd1) begin
                            mosi_d = tx_q[14];
                        end
                    end
                    SMC_NEXT: begin
                        rd_d = rx_q & ((16'h1 << bits_q) - 16'h1);
                        rv_d = (op_q != SMC_OP_BWR);
                        rx_d = 16'h0;
                        left_d = left_q - SMC_CNT_W'(1);
                        if (left_q == SMC_CNT_W'(1)) begin
                            st_d = SMC_IDLE;
                            dn_d = 1'b1;
                            mosi_d = 1'b0;
                        end else begin
                            tx_d = nxt_word << (5'd16 - bits_q);
                            wr_d = (op_q != SMC_OP_BRD);
                            bit_d = bits_q;
                            mosi_d = cpha ? mosi_q : tx_d[15];
                            st_d = SMC_LEAD;
                        end
                    end
                    default: st_d = SMC_IDLE;
                endcase
            end

            // Channel registers
            always_ff @(posedge mclk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    open_q <= 1'b0;
                    mode_q <= SMC_MODE_RST;
                    bits_q <= SMC_BITS_RST;
                    div_q <= SMC_DIV_RST;
                    st_q <= SMC_IDLE;
                    op_q <= SMC_OP_XCHG;
                    tx_q <= 16'h0;
                    rx_q <= 16'h0;
                    rd_q <= 16'h0;
                    bit_q <= 5'h0;
                    left_q <= '0;
                    sclk_q <= 1'b0;
                    mosi_q <= 1'b0;
                    rv_q <= 1'b0;
                    dn_q <= 1'b0;
                    wr_q <= 1'b0;
                    miso_m_q <= 1'b0;
                    miso_s_q <= 1'b0;
                end else begin
                    open_q <= open_d;
                    mode_q <= mode_d;
                    bits_q <= bits_d;
                    div_q <= div_d;
                    st_q <= st_d;
                    op_q <= op_d;
                    tx_q <= tx_d;
                    rx_q <= rx_d;
                    rd_q <= rd_d;
                    bit_q <= bit_d;
                    left_q <= left_d;
                    sclk_q <= sclk_d;
                    mosi_q <= mosi_d;
                    rv_q <= rv_d;
                    dn_q <= dn_d;
                    wr_q <= wr_d;
                    miso_m_q <= miso_i[g];
                    miso_s_q <= miso_m_q;
                end
            end

            // Outputs
            assign rdata_o[g*16 +: 16] = rd_q;
            assign rvalid_o[g] = rv_q;
            assign done_o[g] = dn_q;
            assign wdata_req_o[g] = wr_q;
            assign busy_o[g] = (st_q != SMC_IDLE);
            assign opened_o[g] = open_q;
            assign sclk_o[g] = sclk_q;
            assign mosi_o[g] = mosi_q;
            assign pin_oe_o[g] = open_q;
        end
    endgenerate
endmodule

//--- logic/smc_pkg.sv
// Package for the two-channel serial master block: widths, modes, reset values.
// Assumes a 200 MHz system clock; no bus, all configuration arrives on ports.
package smc_pkg;
    localparam int SMC_CLK_HZ = 200000000;
    localparam int SMC_MIN_BITS = 4;
    localparam int SMC_MAX_BITS = 16;
    localparam int SMC_DIV_W = 16;
    localparam int SMC_CNT_W = 16;
    localparam logic [1:0] SMC_MODE_RST = 2'h0;
    localparam logic [4:0] SMC_BITS_RST = 5'h08;
    localparam logic [15:0] SMC_DIV_RST = 16'h0064;
    // Operation requested with each start
    typedef enum logic [1:0] {
        SMC_OP_XCHG = 2'h0,
        SMC_OP_BWR = 2'h1,
        SMC_OP_BRD = 2'h2
    } smc_op_t;
    // Channel state, Gray along idle-lead-trail-next
    typedef enum logic [2:0] {
        SMC_IDLE = 3'h0,
        SMC_LEAD = 3'h1,
        SMC_TRAIL = 3'h3,
        SMC_NEXT = 3'h2
    } smc_state_t;
endpackage

//--- verif/smc_master_chk.sv
// Checker: timing relations on the serial master ports, channel slices 0 and 1.
// Assumes it is bound into smc_master and sees only that module's ports.
`timescale 1ns/1ps
module smc_master_chk
    import smc_pkg::*;
#(
    parameter int NCH = 2
) (
    // Clock, reset and requests
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [NCH-1:0] open_i,
    input wire logic [NCH-1:0] start_i,
    input wire logic [NCH*2-1:0] op_i,
    // Observed outputs
    input wire logic [NCH-1:0] rvalid_o,
    input wire logic [NCH-1:0] done_o,
    input wire logic [NCH-1:0] busy_o,
    input wire logic [NCH-1:0] opened_o,
    input wire logic [NCH-1:0] sclk_o,
    input wire logic [NCH-1:0] mosi_o,
    input wire logic [NCH-1:0] pin_oe_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // One clock domain for every property
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_idle_clk_hold: assert property (
        !busy_o[0] && opened_o[0] ##1 !busy_o[0] && opened_o[0] |-> $stable(sclk_o[0]))
        else $error("serial clock moved while idle");
    a_closed_park: assert property (
        !opened_o[1] |-> !sclk_o[1] && !mosi_o[1] && !pin_oe_o[1])
        else $error("pins not parked while closed");
    a_oe_follows: assert property (!pin_oe_o[0] |-> !sclk_o[0] && !mosi_o[0])
        else $error("channel 0 pins driven while disabled");
    a_start_busy: assert property (
        start_i[0] && open_i[0] && opened_o[0] && !busy_o[0] |=> busy_o[0])
        else $error("accepted start did not raise busy");
    a_busy_cause: assert property (!busy_o[1] && !start_i[1] |=> !busy_o[1])
        else $error("busy rose without a start");
    a_done_single: assert property (done_o[0] |=> !done_o[0])
        else $error("done longer than one cycle");
    a_done_ends: assert property (done_o[0] |-> ##[0:2] !busy_o[0])
        else $error("busy stayed after done");
    a_clk_busy: assert property (
        $changed(sclk_o[0]) && $past(opened_o[0]) && opened_o[0] |-> busy_o[0] || $past(busy_o[0]))
        else $error("serial clock moved outside a transfer");
    a_read_zeros: assert property (
        start_i[0] && op_i[1:0] == SMC_OP_BRD && opened_o[0] && !busy_o[0] && open_i[0]
        |=> !mosi_o[0] [*8]) else $error("bulk read sent a one");
    a_rvalid_single: assert property (rvalid_o[1] |=> !rvalid_o[1])
        else $error("rvalid longer than one cycle");
endmodule

//--- verif/smc_slave_model.sv
// Behavioural serial slave: sends tx_i MSB first, shifts mosi into rx_o.
// Assumes mode and width match the master; load_i rearms it between frames.
`timescale 1ns/1ps
module smc_slave_model (
    // Clock, reset and control
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] mode_i,
    input wire logic [4:0] bits_i,
    input wire logic load_i,
    input wire logic [15:0] tx_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Observation
    output logic [15:0] rx_o,
    output logic [7:0] words_o
);
    logic prev_q, st_q, tog_q, edg, lead, samp;
    logic [4:0] idx_q, ns_q;
    // Classify clock edges from the polarity and phase
    assign edg = sclk_i != prev_q;
    assign lead = edg && (prev_q == mode_i[1]);
    assign samp = edg && (lead != mode_i[0]);
    // MSB first; before the first phase-1 edge the line carries no data
    assign miso_o = (mode_i[0] && !st_q) ? tog_q : tx_i[bits_i - 5'h1 - idx_q];
    // Shift state, cleared by reset or load
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i || load_i) begin
            prev_q <= sclk_i;
            {st_q, tog_q, idx_q, ns_q, rx_o, words_o} <= '0;
        end else begin
            prev_q <= sclk_i;
            tog_q <= !tog_q;
            if (samp) begin
                rx_o <= {rx_o[14:0], mosi_i};
                ns_q <= (ns_q == bits_i - 5'h1) ? 5'h00 : ns_q + 5'h01;
                words_o <= words_o + 8'((ns_q == bits_i - 5'h1));
            end
            if (edg && !samp) begin
                st_q <= 1'b1;
                if (st_q || !mode_i[0]) begin
                    idx_q <= (idx_q == bits_i - 5'h1) ? 5'h00 : idx_q + 5'h01;
                end
            end
        end
    end
endmodule

//--- verif/tb_smc_master.sv
// Testbench: exchanges in all four modes, modes 0 and 2 on channel 0, 1 and 3 on channel 1, bulk transfers, close.
// Assumes smc_master with two channels and a 200 MHz clock.
`timescale 1ns/1ps
module tb_smc_master;
    import smc_pkg::*;
    logic mclk_i = 0, rst_b_i = 0;
    logic [1:0] open_i = 0, start_i = 0, miso, ld = 0, wdata_req_o, rvalid_o, done_o;
    logic [1:0] busy_o, opened_o, sclk_o, mosi_o, pin_oe_o;
    logic [63:0] rate_hz_i = {2{32'h00989680}};
    logic [3:0] mode_i = 0, op_i = 0;
    logic [9:0] bits_i = 10'h108;
    logic [31:0] count_i = 0, wdata_i = 0, stx = 0, rdata_o, srx;
    logic [15:0] words;
    int bad_count = 0, checked = 0, cycles = 0, nk = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and one slave per channel
    initial forever #2.5 mclk_i = !mclk_i;
    smc_master uut (.mclk_i, .rst_b_i, .open_i, .rate_hz_i, .mode_i, .bits_i, .start_i,
        .op_i, .count_i, .wdata_i, .wdata_req_o, .rdata_o, .rvalid_o, .done_o, .busy_o,
        .opened_o, .sclk_o, .mosi_o, .pin_oe_o, .miso_i(miso));
    for (genvar g = 0; g < 2; g++) begin : g_sl
        smc_slave_model sl (.mclk_i, .rst_b_i, .mode_i(mode_i[2*g+:2]), .bits_i(bits_i[5*g+:5]),
            .load_i(ld[g]), .tx_i(stx[16*g+:16]), .sclk_i(sclk_o[g]), .mosi_i(mosi_o[g]),
            .miso_o(miso[g]), .rx_o(srx[16*g+:16]), .words_o(words[8*g+:8]));
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic open_ch(input int c, input logic [1:0] m, input logic [4:0] b);
        open_i[c] = 0;
        cyc(2);
        mode_i[2*c+:2] = m;
        bits_i[5*c+:5] = b;
        open_i[c] = 1;
        cyc(3);
        chk(opened_o[c], 1'b1);
    endtask
    task automatic run(input int c, input logic [1:0] op, input logic [15:0] n, w, s, er,
        output int nrv);
        int k;
        int nwr;
        nrv = 0;
        nwr = 0;
        k = 0;
        {op_i[2*c+:2], count_i[16*c+:16], wdata_i[16*c+:16], stx[16*c+:16]} = {op, n, w, s};
        // Rearm the slave, standing in for its select, before each transaction
        ld[c] = 1;
        cyc(1);
        ld[c] = 0;
        start_i[c] = 1;
        cyc(1);
        start_i[c] = 0;
        chk(busy_o[c], op == SMC_OP_XCHG || n != 16'h0);
        // Look at every one-cycle pulse while it stands, the start cycle included
        forever begin
            if (wdata_req_o[c] === 1'b1) begin
                nwr++;
            end
            if (rvalid_o[c] === 1'b1) begin
                nrv++;
                chk(rdata_o[16*c+:16], er);
            end
            if (done_o[c] === 1'b1 || k == 20000) begin
                break;
            end
            cyc(1);
            k++;
        end
        nk = k;
        chk(k < 20000, 1);
        chk(busy_o[c], 1'b0);
        chk(nwr, (op == SMC_OP_BRD) ? 0 : (op == SMC_OP_XCHG) ? 1 : int'(n));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_xchg();
        logic [4:0] b;
        logic [15:0] mk;
        int n;
        for (int m = 0; m < 4; m++) begin
            b = 5'(4 * m + 4);
            mk = 16'((32'h1 << b) - 32'h1);
            open_ch(m % 2, 2'(m), b);
            chk(sclk_o[m % 2], m / 2);
            run(m % 2, SMC_OP_XCHG, 16'h1, 16'hc5a3, 16'h9e36, 16'h9e36 & mk, n);
            chk(n, 1);
            // Two half periods per bit at the bench rate, plus the word-end cycle
            chk(nk, 2 * b * (SMC_CLK_HZ / (2 * rate_hz_i[31:0])) + 1);
            chk(srx[16*(m%2)+:16] & mk, 16'hc5a3 & mk);
            chk(sclk_o[m % 2], m / 2);
        end
        $display("exchange in four modes finished");
    endtask
    task automatic t_bulk();
        int n;
        open_ch(0, 2'h0, 5'h08);
        run(0, SMC_OP_BWR, 16'h3, 16'h005a, 16'h00ff, 16'h0000, n);
        chk(n, 0);
        chk({words[7:0], srx[7:0]}, 16'h035a);
        run(0, SMC_OP_BRD, 16'h2, 16'h00ff, 16'h0096, 16'h0096, n);
        chk(n, 2);
        chk({words[7:0], srx[7:0]}, 16'h0200);
        run(1, SMC_OP_BWR, 16'h0, 16'h00ff, 16'h0000, 16'h0000, n);
        chk(words[15:8], 0);
        $display("bulk transfers finished");
    endtask
    task automatic t_close();
        open_i = 2'h0;
        cyc(4);
        chk({opened_o, pin_oe_o, sclk_o, mosi_o}, 0);
        $display("close finished");
    endtask
    task automatic print_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("ERROR %0t run too long", $time);
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        cyc(12);
        rst_b_i = 1;
        t_xchg();
        t_bulk();
        t_close();
        print_verdict();
    end
endmodule
bind smc_master smc_master_chk #(.NCH(NCH)) u_chk (.*);
